// ### design/itrp_pkg.sv
// constants and types of the two-wire target register port
//=====================================================================
// Function
// [RL1] the port answers a 7-bit target address of fixed upper bits 1011 and three strap bits below.
// [RL2] with all three straps high the port answers at 1011 111, other strap levels pick the other addresses.
// [RL3] the port works at any bus rate up to 400 kHz and the host stays within that rate.
// [RL4] each register holds 24 bits and moves as three separate 8-bit bytes.
// [RL5] register bytes travel low byte first, bits 7:0, then 15:8, then 23:16, for reads and writes.
// [RL6] the port acknowledges every written byte and the host acknowledges every byte the port sends;
// the port NACKs bytes after a single-mode register, the host model NACKs the last read byte.
// [RL7] the port offers single-register access and continuous access with an advancing register address.
// [RL8] continuous access is switched on by bit 6 of the register at address 00h.
// [RL9] a write frame is target address, one register address byte, three data bytes; a read sets the address and restarts reading.
// [RL10] in continuous mode the register address steps by one after each full register and runs until a stop.
package itrp_pkg;
  //===================================================================
  // addressing and register layout
  localparam logic [3:0]  ADDR_FIXED  = 4'hb;
  localparam logic [7:0]  REG_CFG     = 8'h00;
  localparam int          CONT_BIT    = 6;
  localparam logic [23:0] CFG_RESET   = 24'h000000;
  localparam logic [1:0]  BYTE_LAST   = 2'h2;
  localparam logic [3:0]  BIT_LAST    = 4'h8;
  //===================================================================
  // bus timing figures
  localparam int          BUS_MAX_KHZ = 400;
  localparam int          LINK_MHZ    = 83;
  localparam int          LINK_PER_BIT = LINK_MHZ * 1000 / BUS_MAX_KHZ;
  //===================================================================
  // link state machine
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REGA, ST_ACK_REGA,
    ST_WDATA, ST_ACK_WDATA, ST_STALL, ST_RDATA, ST_RACK
  } itrp_state_t;
endpackage : itrp_pkg

// ### design/itrp_top.sv
// two-wire target port holding the 24-bit register bank
`timescale 1ns/1ps
module itrp_top (
  // core clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // link oversampling clock
  input  wire logic         link_clk,
  // serial clock pin, open drain
  input  wire logic         target_serial_clock_pin_in,
  output logic              target_serial_clock_pin_out,
  output logic              target_serial_clock_pin_oe,
  // serial data pin, open drain
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  // address straps
  input  wire logic         addr_select_bit0,
  input  wire logic         addr_select_bit1,
  input  wire logic         addr_select_bit2,
  // register write stream to the core
  output logic              wr_valid,
  output logic [7:0]        wr_addr,
  output logic [23:0]       wr_data,
  input  wire logic         wr_ready,
  // continuous access mode seen by the core
  output logic              continuous_access_enable
);
  import itrp_pkg::*;

  //===================================================================
  // link-domain reset and pin sampling
  logic              lrst_s1, lrst_r;
  logic [4:0]        pin_s1, pin_s2, pin_s3, pin_f;
  logic              scl_q, sda_q;
  logic [1:0]        rg_s1, rg_s2, rptr_r, rgray_r, wg_s1, wg_s2;
  // reset crosses into the link domain on two flops
  always_ff @(posedge link_clk) begin
    lrst_s1 <= rst;
    lrst_r  <= lrst_s1;
  end
  // three flops per pin; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin
      always_ff @(posedge link_clk) begin
        pin_s1[gi] <= (gi == 0) ? target_serial_clock_pin_in :
                      (gi == 1) ? sda_in :
                      (gi == 2) ? addr_select_bit0 :
                      (gi == 3) ? addr_select_bit1 : addr_select_bit2;
        pin_s2[gi] <= pin_s1[gi];
        pin_s3[gi] <= pin_s2[gi];
        if (lrst_r) begin
          pin_f[gi] <= 1'b1;
        end else if (pin_s2[gi] == pin_s3[gi]) begin
          pin_f[gi] <= pin_s3[gi]; // oversampling far above the bit rate RL3
        end
      end
    end
  endgenerate
  always_ff @(posedge link_clk) begin
    scl_q <= pin_f[0];
    sda_q <= pin_f[1];
  end
  wire logic scl_rise = pin_f[0] & ~scl_q;
  wire logic scl_fall = ~pin_f[0] & scl_q;
  wire logic bus_start = pin_f[0] & scl_q & ~pin_f[1] & sda_q;
  wire logic bus_stop  = pin_f[0] & scl_q & pin_f[1] & ~sda_q;
  wire logic [6:0] own_addr = {ADDR_FIXED, pin_f[4:2]}; // RL1 RL2

  //===================================================================
  // register bank, address 00h kept in flops so it has a reset value
  logic [23:0]       regs [256];
  logic [23:0]       reg0_r;
  itrp_state_t       state_r;
  logic [3:0]        bitcnt_r;
  logic [7:0]        sh_r;
  logic [1:0]        idx_r;
  logic [7:0]        ptr_r;
  logic [15:0]       data_r;
  logic              rw_r, done_r, sda_oe_r, scl_oe_r;
  logic [1:0]        wptr_r, wgray_r;
  logic [31:0]       fifo_mem [2];
  wire logic         cont = reg0_r[CONT_BIT]; // RL8
  wire logic         fifo_full = (wgray_r == ~rg_s2);
  wire logic [23:0]  wr_word = {sh_r, data_r}; // RL4 RL5
  wire logic         commit_go = (state_r == ST_WDATA) && scl_fall &&
                                 (bitcnt_r == BIT_LAST) &&
                                 (idx_r == BYTE_LAST) && !done_r;
  wire logic         push = (commit_go || state_r == ST_STALL) && !fifo_full;

  // byte pick for reads, low byte first
  function automatic logic [7:0] pick(input logic [23:0] w,
                                      input logic [1:0] i);
    case (i)
      2'h0:    pick = w[7:0];
      2'h1:    pick = w[15:8];
      default: pick = w[23:16];
    endcase
  endfunction : pick

  // next read position: step the address only in continuous mode
  wire logic        rwrap   = (idx_r == BYTE_LAST);
  wire logic [1:0]  ridx_nxt = rwrap ? 2'h0 : idx_r + 2'h1;
  wire logic [7:0]  rptr_nxt = (rwrap && cont) ? ptr_r + 8'h01 : ptr_r;
  wire logic [23:0] rd_cur = (ptr_r == REG_CFG) ? reg0_r : regs[ptr_r];
  wire logic [23:0] rd_nxt = (rptr_nxt == REG_CFG) ? reg0_r :
                             regs[rptr_nxt];
  wire logic [7:0]  byte_first = pick(rd_cur, idx_r);
  wire logic [7:0]  byte_next  = pick(rd_nxt, ridx_nxt);

  // bank update on every committed register
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      reg0_r <= CFG_RESET;
    end else if (push && ptr_r == REG_CFG) begin
      reg0_r <= wr_word;
    end
    if (push && ptr_r != REG_CFG) begin
      regs[ptr_r] <= wr_word;
    end
  end

  //===================================================================
  // frame engine; start and stop override every state
  always_ff @(posedge link_clk) begin
    if (lrst_r || bus_stop) begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
      bitcnt_r <= 4'h0;
    end else if (bus_start) begin
      state_r  <= ST_ADDR; // repeated start keeps the pointer RL9
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
      bitcnt_r <= 4'h0;
    end else begin
      case (state_r)
        ST_ADDR, ST_REGA, ST_WDATA: begin
          if (scl_rise) begin
            sh_r     <= {sh_r[6:0], pin_f[1]};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == BIT_LAST) begin
            bitcnt_r <= 4'h0;
            if (state_r == ST_ADDR) begin
              if (sh_r[7:1] == own_addr) begin
                rw_r     <= sh_r[0];
                sda_oe_r <= 1'b1; // RL1 RL6
                state_r  <= ST_ACK_ADDR;
              end else begin
                state_r  <= ST_IDLE;
              end
            end else if (state_r == ST_REGA) begin
              sda_oe_r <= 1'b1; // RL6
              state_r  <= ST_ACK_REGA;
            end else if (done_r) begin
              state_r  <= ST_IDLE; // single access: extra bytes NACKed RL7
            end else if (idx_r != BYTE_LAST) begin
              if (idx_r == 2'h0) data_r[7:0] <= sh_r; // RL5
              else data_r[15:8] <= sh_r;
              sda_oe_r <= 1'b1; // RL6
              state_r  <= ST_ACK_WDATA;
            end else if (fifo_full) begin
              scl_oe_r <= 1'b1; // hold the clock low until the core drains
              sda_oe_r <= 1'b1; // ack settles while the clock is low RL6
              state_r  <= ST_STALL;
            end else begin
              sda_oe_r <= 1'b1;
              state_r  <= ST_ACK_WDATA;
            end
          end
        end
        ST_STALL: begin
          if (!fifo_full) begin
            scl_oe_r <= 1'b0; // data must not move while the clock is high
            state_r  <= ST_ACK_WDATA;
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_r) begin
              sh_r     <= {byte_first[6:0], 1'b0};
              sda_oe_r <= ~byte_first[7];
              bitcnt_r <= 4'h1;
              state_r  <= ST_RDATA;
            end else begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_REGA; // RL9
            end
          end
        end
        ST_ACK_REGA, ST_ACK_WDATA: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            state_r  <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bitcnt_r == BIT_LAST) begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_RACK;
            end else begin
              sda_oe_r <= ~sh_r[7];
              sh_r     <= {sh_r[6:0], 1'b0};
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && pin_f[1]) begin
            state_r <= ST_IDLE; // host NACK ends the read RL6
          end else if (scl_fall) begin
            sh_r     <= {byte_next[6:0], 1'b0};
            sda_oe_r <= ~byte_next[7];
            bitcnt_r <= 4'h1;
            state_r  <= ST_RDATA;
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
          scl_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // register pointer and byte position
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      ptr_r  <= REG_CFG;
      idx_r  <= 2'h0;
      done_r <= 1'b0;
    end else if (state_r == ST_REGA && scl_fall && bitcnt_r == BIT_LAST) begin
      ptr_r  <= sh_r;
      idx_r  <= 2'h0;
      done_r <= 1'b0;
    end else if (push) begin
      idx_r  <= 2'h0;
      ptr_r  <= cont ? ptr_r + 8'h01 : ptr_r; // RL7 RL10
      done_r <= ~cont;
    end else if (state_r == ST_WDATA && scl_fall && bitcnt_r == BIT_LAST &&
                 !done_r && idx_r != BYTE_LAST) begin
      idx_r  <= idx_r + 2'h1; // RL4
    end else if (state_r == ST_RACK && scl_fall) begin
      idx_r  <= ridx_nxt; // RL5
      ptr_r  <= rptr_nxt; // RL10
    end else if (state_r != ST_WDATA && state_r != ST_ACK_WDATA &&
                 state_r != ST_STALL && state_r != ST_RDATA &&
                 state_r != ST_RACK) begin
      idx_r <= (state_r == ST_ACK_ADDR) ? idx_r : 2'h0;
    end
  end

  //===================================================================
  // two-entry crossing buffer, gray pointers; full stretches the clock
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      wptr_r  <= 2'h0;
      wgray_r <= 2'h0;
    end else if (push) begin
      wptr_r  <= wptr_r + 2'h1;
      wgray_r <= (wptr_r + 2'h1) ^ ((wptr_r + 2'h1) >> 1);
    end
    if (push) begin
      fifo_mem[wptr_r[0]] <= {ptr_r, wr_word};
    end
    rg_s1 <= rgray_r;
    rg_s2 <= rg_s1;
  end

  logic              wr_valid_r, cont_s1, cont_s2;
  logic [31:0]       wr_word_r;
  wire logic         fifo_empty = (rgray_r == wg_s2);
  wire logic         pop = !fifo_empty && (!wr_valid_r || wr_ready);
  // core side drains into an output register; a stalled core fills it
  always_ff @(posedge clk) begin
    wg_s1   <= wgray_r;
    wg_s2   <= wg_s1;
    cont_s1 <= cont;
    cont_s2 <= cont_s1;
    if (rst) begin
      rptr_r     <= 2'h0;
      rgray_r    <= 2'h0;
      wr_valid_r <= 1'b0;
      wr_word_r  <= 32'h00000000;
    end else begin
      if (pop) begin
        rptr_r    <= rptr_r + 2'h1;
        rgray_r   <= (rptr_r + 2'h1) ^ ((rptr_r + 2'h1) >> 1);
        wr_word_r <= fifo_mem[rptr_r[0]];
      end
      if (pop) wr_valid_r <= 1'b1;
      else if (wr_ready) wr_valid_r <= 1'b0;
    end
  end

  //===================================================================
  // outputs, all from flops
  logic sda_out_r, scl_out_r, cont_out_r;
  always_ff @(posedge link_clk) begin
    sda_out_r <= 1'b0; // open drain: only the enable moves
    scl_out_r <= 1'b0;
  end
  always_ff @(posedge clk) begin
    cont_out_r <= rst ? 1'b0 : cont_s2;
  end
  assign sda_out                     = sda_out_r;
  assign sda_oe                      = sda_oe_r;
  assign target_serial_clock_pin_out = scl_out_r;
  assign target_serial_clock_pin_oe  = scl_oe_r;
  assign wr_valid                    = wr_valid_r;
  assign wr_addr                     = wr_word_r[31:24];
  assign wr_data                     = wr_word_r[23:0];
  assign continuous_access_enable    = cont_out_r;

  //===================================================================
  // checks
  addr_match_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL1
    state_r == ST_ADDR && scl_fall && bitcnt_r == BIT_LAST &&
      sh_r[7:1] != own_addr |=> state_r == ST_IDLE && !sda_oe_r)
    else $error("foreign address not ignored");
  ack_addr_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL1
    $rose(state_r == ST_ACK_ADDR) |-> $past(sh_r[7:4]) == ADDR_FIXED &&
      $past(sh_r[3:1]) == pin_f[4:2])
    else $error("acked a foreign address");
  default_addr_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL2
    $rose(state_r == ST_ACK_ADDR) && pin_f[4:2] == 3'h7 |->
      $past(sh_r[7:1]) == 7'h5f)
    else $error("default address wrong");
  ack_drive_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL6
    state_r == ST_ACK_WDATA || state_r == ST_ACK_REGA |-> sda_oe_r)
    else $error("write byte not acknowledged");
  three_bytes_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL4
    push |-> idx_r == BYTE_LAST)
    else $error("register committed before third byte");
  low_first_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL5
    state_r == ST_WDATA && scl_fall && bitcnt_r == BIT_LAST && !done_r &&
      idx_r == 2'h0 |=> data_r[7:0] == $past(sh_r))
    else $error("first data byte not stored low");
  cont_step_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL10
    push && cont |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("continuous address did not step");
  single_hold_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL7
    push && !cont |=> ptr_r == $past(ptr_r) && done_r)
    else $error("single access moved the address");
  cont_bit_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL8
    push && ptr_r == REG_CFG |=> cont == $past(wr_word[CONT_BIT]))
    else $error("continuous bit not taken");
  frame_seq_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL9
    $rose(state_r == ST_REGA) |-> !rw_r && $past(state_r) == ST_ACK_ADDR)
    else $error("register address outside a write frame");
  stall_a: assert property (@(posedge link_clk) disable iff (lrst_r) // RL3
    scl_oe_r |-> state_r == ST_STALL)
    else $error("clock held outside a stall");
  write_c: cover property (@(posedge link_clk) disable iff (lrst_r) push);
  read_c: cover property (@(posedge link_clk) disable iff (lrst_r)
    state_r == ST_RACK ##[1:1000] state_r == ST_RDATA);
  stall_c: cover property (@(posedge link_clk) disable iff (lrst_r)
    state_r == ST_STALL ##1 push);
  drain_c: cover property (@(posedge clk) disable iff (rst)
    wr_valid_r && !wr_ready);
endmodule : itrp_top

// ### design/unused_placeholder_do_not_compile.sv
// intentionally empty: no further design content
`timescale 1ns/1ps

// ### bench/itrp_host_model.sv
// two-wire host model acting on the target port from the far side
`timescale 1ns/1ps
module itrp_host_model #(
  parameter int Q = 7 // core clocks per quarter bit, 357 kHz bus
) (
  // time base
  input  wire logic clk,
  // resolved wire levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // open-drain pulls, high pulls the line low
  output logic      scl_oe,
  output logic      sda_oe
);
  int hang_count;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    hang_count = 0;
  end
  //===================================================================
  // bus primitives, all moves land just after a core clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // release the clock and wait out a stretch, bounded
  task automatic scl_rel();
    int k;
    scl_oe = 1'b0;
    k = 0;
    #1;
    while (scl_in !== 1'b1 && k < 30000) begin
      tick(1);
      k++;
    end
    if (k == 30000) hang_count++;
  endtask : scl_rel
  // serves as first and repeated start
  task automatic start_cond();
    sda_oe = 1'b0;
    tick(Q);
    scl_rel();
    tick(Q);
    sda_oe = 1'b1;
    tick(Q);
    scl_oe = 1'b1;
    tick(Q);
  endtask : start_cond
  task automatic stop_cond();
    sda_oe = 1'b1;
    tick(Q);
    scl_rel();
    tick(Q);
    sda_oe = 1'b0;
    tick(Q);
  endtask : stop_cond
  // data only changes while the clock is low
  task automatic bit_xfer(input logic b, output logic r);
    sda_oe = !b;
    tick(Q);
    scl_rel();
    tick(Q);
    r = sda_in;
    tick(Q);
    scl_oe = 1'b1;
    tick(Q);
  endtask : bit_xfer
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
    bit_xfer(1'b1, r);
    ack = !r;
  endtask : wr_byte
  // host acknowledges each read byte, nack on the last
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
    bit_xfer(nack, r);
  endtask : rd_byte
endmodule : itrp_host_model

// ### bench/itrp_top_tb.sv
// self-checking bench for the two-wire target register port
`timescale 1ns/1ps
module itrp_top_tb;
  import itrp_pkg::*;
  //===================================================================
  // signals
  localparam int         TIMEOUT = 80000; // run needs about 20000
  localparam logic [7:0] DEV_W   = {ADDR_FIXED, 3'h7, 1'b0};
  logic        clk, link_clk, rst, wr_ready, wr_valid, cont;
  logic        addr_select_bit0, addr_select_bit1, addr_select_bit2;
  logic        scl_w, sda_w, d_scl_oe, d_sda_oe, h_scl_oe, h_sda_oe;
  logic        scl_o, sda_o;
  logic [7:0]  wr_addr, ackv_b;
  logic [23:0] wr_data;
  logic [15:0] ackv;
  logic [7:0]  fq[$];
  logic [7:0]  rq[$];
  logic [31:0] wq[$];
  int          err_count, cmp_count, cyc;
  // open-drain wires with pull-up
  assign scl_w = !(d_scl_oe | h_scl_oe);
  assign sda_w = !(d_sda_oe | h_sda_oe);
  always #50 clk = ~clk;
  always #6 link_clk = ~link_clk;
  //===================================================================
  // instances
  itrp_top itrp_top_inst (
    .clk(clk), .rst(rst), .link_clk(link_clk),
    .target_serial_clock_pin_in(scl_w),
    .target_serial_clock_pin_out(scl_o),
    .target_serial_clock_pin_oe(d_scl_oe),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe(d_sda_oe),
    .addr_select_bit0(addr_select_bit0),
    .addr_select_bit1(addr_select_bit1),
    .addr_select_bit2(addr_select_bit2),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_ready(wr_ready), .continuous_access_enable(cont));
  itrp_host_model itrp_host_model_inst (
    .clk(clk), .scl_in(scl_w), .sda_in(sda_w),
    .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));
  // collects every word the core takes; timeout guard
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      wq.push_back({wr_addr, wr_data});
    cyc++;
    if (cyc == TIMEOUT) begin
      err_count++;
      complete_run();
    end
  end
  //===================================================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // one frame of the bytes queued in fq, ack bit per byte
  task automatic wr_frame();
    logic a;
    ackv = '0;
    itrp_host_model_inst.start_cond();
    foreach (fq[i]) begin
      itrp_host_model_inst.wr_byte(fq[i], a);
      ackv[i] = a;
    end
    itrp_host_model_inst.stop_cond();
  endtask : wr_frame
  // set pointer, restart reading, n bytes into rq
  task automatic rd_frame(input logic [7:0] ra, input int n);
    logic       a;
    logic [7:0] b;
    rq = {};
    itrp_host_model_inst.start_cond();
    itrp_host_model_inst.wr_byte(DEV_W, a);
    itrp_host_model_inst.wr_byte(ra, a);
    itrp_host_model_inst.start_cond();
    itrp_host_model_inst.wr_byte(DEV_W | 8'h01, a);
    for (int i = 0; i < n; i++) begin
      itrp_host_model_inst.rd_byte(i == n - 1, b);
      rq.push_back(b);
    end
    itrp_host_model_inst.stop_cond();
  endtask : rd_frame
  task automatic expect_word(input logic [7:0] ea, input logic [23:0] ed);
    int k;
    k = 0;
    while (wq.size() == 0 && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    check("word present", 32'(wq.size() > 0), 32'h1);
    if (wq.size() > 0) check("word", wq.pop_front(), {ea, ed});
  endtask : expect_word
  //===================================================================
  // main sequence
  initial begin
    clk = 1'b0;
    link_clk = 1'b0;
    rst = 1'b1;
    wr_ready = 1'b1;
    {addr_select_bit2, addr_select_bit1, addr_select_bit0} = 3'h7;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check("wr_valid", wr_valid, 0);
    check("continuous", cont, 0);
    check("sda_oe", d_sda_oe, 0);
    check("sda_out", sda_o, 0);
    check("scl_oe", d_scl_oe, 0);
    check("scl_out", scl_o, 0);
    rd_frame(REG_CFG, 3);
    check("cfg reset", {rq[2], rq[1], rq[0]}, CFG_RESET);
    // each strap code acks its own address; the address with the inverted strap code is nacked
    for (int s = 0; s < 8; s++) begin
      {addr_select_bit2, addr_select_bit1, addr_select_bit0} = 3'(s);
      repeat (10) @(posedge clk);
      #1;
      fq = '{{ADDR_FIXED, 3'(s), 1'b0}};
      wr_frame();
      check("strap addr ack", ackv, 1);
      fq = '{{ADDR_FIXED, ~3'(s), 1'b0}};
      wr_frame();
      check("other addr nack", ackv, 0);
    end
    fq = '{{4'h3, 3'h7, 1'b0}};
    wr_frame();
    check("upper bits nack", ackv, 0);
    // single mode, fourth data byte refused
    fq = '{DEV_W, 8'h05, 8'h21, 8'h43, 8'h65, 8'h99};
    wr_frame();
    check("single acks", ackv, 16'h001f);
    expect_word(8'h05, 24'h654321);
    rd_frame(8'h05, 4);
    check("read", {rq[0], rq[1], rq[2], rq[3]}, 32'h21436521);
    // a register cut short is dropped
    fq = '{DEV_W, 8'h0a, 8'h11, 8'h22};
    wr_frame();
    check("partial acks", ackv, 16'h000f);
    repeat (300) @(posedge clk);
    check("partial dropped", wq.size(), 0);
    fq = '{DEV_W, REG_CFG, 8'h40, 8'h00, 8'h00};
    wr_frame();
    expect_word(REG_CFG, 24'h000040);
    repeat (5) @(posedge clk);
    check("continuous", cont, 1);
    // four registers while the core stalls, stretch expected
    fq = '{DEV_W, 8'h06};
    for (int k = 1; k <= 12; k++) fq.push_back(8'(k));
    wr_ready = 1'b0;
    fork
      wr_frame();
      begin
        repeat (5000) @(posedge clk);
        #1;
        check("stretch", d_scl_oe, 1);
        check("held words", wq.size(), 0);
        wr_ready = 1'b1;
      end
    join
    check("cont acks", ackv, 16'h3fff);
    for (int i = 0; i < 4; i++)
      expect_word(8'(6 + i), {8'(3*i+3), 8'(3*i+2), 8'(3*i+1)});
    rd_frame(8'h06, 6);
    for (int i = 0; i < 6; i++) check("cont read", rq[i], 8'(i + 1));
    check("host stretch wait", itrp_host_model_inst.hang_count, 0);
    complete_run();
  end
endmodule : itrp_top_tb
